//--- core/fptm_monitor.sv
// Probe excitation timing, overload latch, error supervision and register slave
`timescale 1ns/1ps

// Functional notes
// - Reverse excitation polarity on each saturation event; loop self-oscillates 250 to 550 kHz.
// - Both polarities handled identically, so zero field gives 50 percent duty.
// - Track flux polarity state and measure every half-period continuously.
// - No half-period ends before 280 ns, even with early saturation.
// - Overload frequency rises toward 1.6 MHz but stays under the timing limit.
// - Three consecutive short halves of one polarity enter overload latch.
// - On latch entry store compensation polarity, keep producing skewed PWM.
// - Leave overload latch only once both halves exceed 280 ns again.
// - Comparator low over 32 us asserts error and forces compensation to zero.
// - Full period under 275 ns on three consecutive pulses asserts error.
// - Drive probe waveform on two complementary PWM outputs.
// - Gain select high requests 8 dB lower internal loop gain.
// - One clock with counters times demagnetize_request, power-up, overload and errors.
// - Demagnetization starts on external request, or at power-up if the request pin is high.
// - Request held 25.6 us starts 110 ms cycle; error held throughout.
// - Error output is open drain, asserted by pulling low.
module fptm_monitor #(
	parameter int unsigned DEMAGNETIZE_REQUEST_RUN_CYC = fptm_pkg::DEMAGNETIZE_REQUEST_RUN_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic probe_saturation_comparator,
	input wire logic demagnetize_request,
	input wire logic gain_select,
	input wire logic error_n_in,
	output logic probe_drive_a,
	output logic probe_drive_b,
	output logic pwm_p,
	output logic pwm_n,
	output logic gain_reduce,
	output logic comp_force_zero,
	output logic overload_latch,
	output logic held_polarity,
	output logic demagnetize_request_active,
	output logic error_n_out,
	output logic error_n_oe
);

	fptm_pkg::fptm_state_t st_q;
	fptm_pkg::fptm_state_t st_d;
	fptm_pkg::fptm_demagnetize_request_t dm;
	logic sat_evt;
	logic reversal;
	logic short_half;
	logic bus_take;

	// ********************************
	// Demagnetization sequencer
	// ********************************
	fptm_demagnetize_request_seq #(
		.RUN_CYC(DEMAGNETIZE_REQUEST_RUN_CYC)
	) u_demagnetize_request (
		.clk(clk),
		.reset(reset),
		.req_level(st_q.dmg_s2),
		.sw_start(st_q.demagnetize_request_sw),
		.dm_status(dm)
	);

	// Saturation edge and the half-period decision
	assign sat_evt = st_q.cmp_s2 && !st_q.cmp_prev;
	assign reversal = (sat_evt || st_q.early) && (st_q.half_cnt >= fptm_pkg::CNT_W'(fptm_pkg::MIN_HALF_CYC));
	assign short_half = st_q.early;
	assign bus_take = hsel && hready && htrans[fptm_pkg::HTRANS_ACTIVE_BIT];

	// Register read mux
	function automatic logic [31:0] read_word(
		input logic [fptm_pkg::ADDR_W-1:0] a,
		input fptm_pkg::fptm_state_t s,
		input fptm_pkg::fptm_demagnetize_request_t d
	);
		logic [31:0] w;
		w = '0;
		unique case (a)
			fptm_pkg::REG_CTRL:
				w[fptm_pkg::CTRL_GAIN_BIT] = s.gain_sw;
			fptm_pkg::REG_STATUS:
			begin
				w[fptm_pkg::ST_LATCH_BIT] = (s.mode == fptm_pkg::OV_LATCH);
				w[fptm_pkg::ST_HELD_BIT] = s.held_pol;
				w[fptm_pkg::ST_STUCK_BIT] = s.stuck_err;
				w[fptm_pkg::ST_FAST_BIT] = s.fast_err;
				w[fptm_pkg::ST_DEMAGNETIZE_REQUEST_BIT] = d.active;
				w[fptm_pkg::ST_ERRPIN_BIT] = s.errp_s2;
				w[fptm_pkg::ST_DRIVE_BIT] = s.drive_pol;
				w[fptm_pkg::ST_PWRUP_BIT] = d.powerup_done;
				w[fptm_pkg::ST_GAIN_BIT] = s.gain_red;
			end
			fptm_pkg::REG_HALF:
			begin
				w[fptm_pkg::HALF_HI_LSB-1:0] = s.last_half[0];
				w[31:fptm_pkg::HALF_HI_LSB] = s.last_half[1];
			end
			default:
				w = '0;
		endcase
		return w;
	endfunction

	// ********************************
	// Next state
	// ********************************
	always_comb
	begin
		st_d = st_q;
		// Two-stage synchronisers for every pin input
		st_d.cmp_s1 = probe_saturation_comparator;
		st_d.cmp_s2 = st_q.cmp_s1;
		st_d.cmp_prev = st_q.cmp_s2;
		st_d.dmg_s1 = demagnetize_request;
		st_d.dmg_s2 = st_q.dmg_s1;
		st_d.gain_s1 = gain_select;
		st_d.gain_s2 = st_q.gain_s1;
		st_d.errp_s1 = error_n_in;
		st_d.errp_s2 = st_q.errp_s1;

		// Half-period timing, same threshold for both polarities
		if (reversal)
		begin
			st_d.drive_pol = !st_q.drive_pol;
			st_d.drive_inv = st_q.drive_pol;
			st_d.half_cnt = fptm_pkg::CNT_W'(1);
			st_d.early = 1'b0;
			st_d.last_half[st_q.drive_pol] = st_q.half_cnt;
			if (short_half)
			begin
				st_d.short_run[st_q.drive_pol] = fptm_pkg::run_inc(st_q.short_run[st_q.drive_pol]);
				st_d.long_seen[st_q.drive_pol] = 1'b0;
			end
			else
			begin
				st_d.short_run[st_q.drive_pol] = '0;
				st_d.long_seen[st_q.drive_pol] = 1'b1;
			end
		end
		else
		begin
			// Early saturation is held until the minimum half-period is met
			if (sat_evt)
				st_d.early = 1'b1;
			st_d.half_cnt = fptm_pkg::cnt_inc(st_q.half_cnt);
		end

		// Overload latch mode
		unique case (st_q.mode)
			fptm_pkg::OV_NORMAL:
			begin
				if (reversal && short_half &&
					st_q.short_run[st_q.drive_pol] == fptm_pkg::RUNC_W'(fptm_pkg::SHORT_RUN_TRIG - 1))
				begin
					st_d.mode = fptm_pkg::OV_LATCH;
					st_d.held_pol = st_q.drive_pol;
					st_d.long_seen = '0;
				end
			end
			fptm_pkg::OV_LATCH:
			begin
				if (st_d.long_seen == '1)
					st_d.mode = fptm_pkg::OV_NORMAL;
			end
		endcase

		// Full-period check between saturation events
		if (sat_evt)
		begin
			if (st_q.period_cnt < fptm_pkg::CNT_W'(fptm_pkg::FAST_PERIOD_CYC))
				st_d.fast_run = fptm_pkg::run_inc(st_q.fast_run);
			else
				st_d.fast_run = '0;
			st_d.period_cnt = fptm_pkg::CNT_W'(1);
		end
		else
			st_d.period_cnt = fptm_pkg::cnt_inc(st_q.period_cnt);
		st_d.fast_err = (st_d.fast_run == fptm_pkg::RUNC_W'(fptm_pkg::FAST_RUN_TRIG));

		// Stuck-low watchdog on the comparator
		if (st_q.cmp_s2)
			st_d.low_cnt = '0;
		else
			st_d.low_cnt = fptm_pkg::cnt_inc(st_q.low_cnt);
		st_d.stuck_err = (st_d.low_cnt > fptm_pkg::CNT_W'(fptm_pkg::STUCK_LOW_CYC));

		// Error drive combines all faults and demagnetization
		st_d.err_drive = st_d.stuck_err || st_d.fast_err || dm.active;

		// Register writes land in the data phase
		st_d.demagnetize_request_sw = 1'b0;
		if (st_q.wr_pend && st_q.wr_addr == fptm_pkg::REG_CTRL)
		begin
			st_d.demagnetize_request_sw = hwdata[fptm_pkg::CTRL_DEMAGNETIZE_REQUEST_BIT];
			st_d.gain_sw = hwdata[fptm_pkg::CTRL_GAIN_BIT];
		end
		st_d.gain_red = st_q.gain_s2 || st_d.gain_sw;

		// Address phase: capture writes, prepare read data from next state
		st_d.wr_pend = 1'b0;
		if (bus_take)
		begin
			st_d.wr_pend = hwrite;
			st_d.wr_addr = haddr[fptm_pkg::ADDR_W-1:0];
			if (!hwrite)
				st_d.rdata = read_word(haddr[fptm_pkg::ADDR_W-1:0], st_d, dm);
		end
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (reset)
			st_q <= '{mode: fptm_pkg::OV_NORMAL, drive_inv: 1'b1, errp_s1: 1'b1, errp_s2: 1'b1, default: '0};
		else
			st_q <= st_d;
	end

	// ********************************
	// Outputs
	// ********************************
	assign hreadyout = 1'b1;
	assign hresp = fptm_pkg::HRESP_OKAY;
	assign hrdata = st_q.rdata;
	assign probe_drive_a = st_q.drive_pol;
	assign probe_drive_b = st_q.drive_inv;
	assign pwm_p = st_q.drive_pol;
	assign pwm_n = st_q.drive_inv;
	assign gain_reduce = st_q.gain_red;
	assign comp_force_zero = st_q.stuck_err;
	assign overload_latch = (st_q.mode == fptm_pkg::OV_LATCH);
	assign held_polarity = st_q.held_pol;
	assign demagnetize_request_active = dm.active;
	// Open drain: the line is only ever pulled low
	assign error_n_out = 1'b0;
	assign error_n_oe = st_q.err_drive;

	// ********************************
	// Checks
	// ********************************
	a_min_half_period: assert property (@(posedge clk) disable iff (reset)
		$changed(st_q.drive_pol) |-> $past(st_q.half_cnt) >= fptm_pkg::CNT_W'(fptm_pkg::MIN_HALF_CYC))
		else $error("Half-period shorter than the minimum");
	a_pwm_complement: assert property (@(posedge clk) disable iff (reset)
		pwm_p != pwm_n && probe_drive_a != probe_drive_b)
		else $error("PWM outputs not complementary");
	a_half_recorded: assert property (@(posedge clk) disable iff (reset)
		$changed(st_q.drive_pol) |-> st_q.last_half[!st_q.drive_pol] == $past(st_q.half_cnt))
		else $error("Half-period length not recorded");
	a_latch_entry: assert property (@(posedge clk) disable iff (reset)
		$rose(overload_latch) |-> $past(short_half) && held_polarity == $past(st_q.drive_pol) &&
			$past(st_q.short_run[st_q.drive_pol]) == fptm_pkg::RUNC_W'(fptm_pkg::SHORT_RUN_TRIG - 1))
		else $error("Overload latch entered without three short halves");
	a_latch_polarity: assert property (@(posedge clk) disable iff (reset)
		overload_latch && $past(overload_latch) |-> $stable(held_polarity))
		else $error("Held polarity changed during overload latch");
	a_latch_exit: assert property (@(posedge clk) disable iff (reset)
		$fell(overload_latch) |-> st_q.long_seen == '1 && $past(reversal) && !$past(short_half))
		else $error("Overload latch left without two long halves");
	a_stuck_error: assert property (@(posedge clk) disable iff (reset)
		$rose(st_q.stuck_err) |-> $past(st_q.low_cnt) == fptm_pkg::CNT_W'(fptm_pkg::STUCK_LOW_CYC)
			##1 (comp_force_zero && error_n_oe))
		else $error("Stuck-low error timing wrong");
	a_fast_error: assert property (@(posedge clk) disable iff (reset)
		$rose(st_q.fast_err) |-> $past(sat_evt) &&
			$past(st_q.period_cnt) < fptm_pkg::CNT_W'(fptm_pkg::FAST_PERIOD_CYC) ##1 error_n_oe)
		else $error("Fast-period error without a short period");
	a_gain_follow: assert property (@(posedge clk) disable iff (reset)
		st_q.gain_s2 |=> gain_reduce)
		else $error("Gain reduction not following gain select");
	a_demagnetize_request_error: assert property (@(posedge clk) disable iff (reset)
		dm.active |=> error_n_oe && !error_n_out)
		else $error("Error not asserted during demagnetization");

endmodule

//--- core/fptm_pkg.sv
// Constants, types and state layouts shared by the probe timing monitor
package fptm_pkg;

	// ********************************
	// Clock and timing figures
	// ********************************
	localparam int unsigned CLK_PERIOD_PS = 25000;
	localparam int unsigned PS_PER_NS = 1000;
	localparam int unsigned CYC_PER_MS = 1000000000 / CLK_PERIOD_PS;
	localparam int unsigned MIN_HALF_NS = 280;
	localparam int unsigned FAST_PERIOD_NS = 275;
	localparam int unsigned STUCK_LOW_NS = 32000;
	localparam int unsigned DEMAGNETIZE_REQUEST_HOLD_NS = 25600;
	localparam int unsigned POWERUP_DELAY_NS = 12000;
	localparam int unsigned DEMAGNETIZE_REQUEST_RUN_MS = 110;
	// Nominal probe frequency window and overload ceiling, for reference
	localparam int unsigned PROBE_FMIN_KHZ = 250;
	localparam int unsigned PROBE_FMAX_KHZ = 550;
	localparam int unsigned OVERLOAD_FMAX_KHZ = 1600;

	// Least times round up, thresholds and longest times round down
	localparam int unsigned MIN_HALF_CYC = (MIN_HALF_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned FAST_PERIOD_CYC = (FAST_PERIOD_NS * PS_PER_NS) / CLK_PERIOD_PS;
	localparam int unsigned STUCK_LOW_CYC = (STUCK_LOW_NS * PS_PER_NS) / CLK_PERIOD_PS;
	localparam int unsigned DEMAGNETIZE_REQUEST_HOLD_CYC = (DEMAGNETIZE_REQUEST_HOLD_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned POWERUP_DELAY_CYC = (POWERUP_DELAY_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned DEMAGNETIZE_REQUEST_RUN_CYC = DEMAGNETIZE_REQUEST_RUN_MS * CYC_PER_MS;
	localparam int unsigned SHORT_RUN_TRIG = 3;
	localparam int unsigned FAST_RUN_TRIG = 3;

	// ********************************
	// Widths
	// ********************************
	localparam int unsigned CNT_W = 16;
	localparam int unsigned RUNC_W = 2;
	localparam int unsigned HOLD_W = 11;
	localparam int unsigned PWRUP_W = 9;
	localparam int unsigned RUN_W = 24;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// ********************************
	// Register map and fields
	// ********************************
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_HALF = 8'h08;
	localparam int unsigned CTRL_DEMAGNETIZE_REQUEST_BIT = 0;
	localparam int unsigned CTRL_GAIN_BIT = 1;
	localparam int unsigned ST_LATCH_BIT = 0;
	localparam int unsigned ST_HELD_BIT = 1;
	localparam int unsigned ST_STUCK_BIT = 2;
	localparam int unsigned ST_FAST_BIT = 3;
	localparam int unsigned ST_DEMAGNETIZE_REQUEST_BIT = 4;
	localparam int unsigned ST_ERRPIN_BIT = 5;
	localparam int unsigned ST_DRIVE_BIT = 6;
	localparam int unsigned ST_PWRUP_BIT = 7;
	localparam int unsigned ST_GAIN_BIT = 8;
	localparam int unsigned HALF_HI_LSB = 16;
	localparam int unsigned HTRANS_ACTIVE_BIT = 1;
	localparam logic HRESP_OKAY = 1'b0;

	// ********************************
	// Types
	// ********************************
	typedef enum logic {OV_NORMAL, OV_LATCH} fptm_ov_mode_t;
	typedef enum logic [1:0] {DM_POWERUP, DM_IDLE, DM_RUN} fptm_dm_mode_t;

	typedef struct packed {
		logic active;
		logic powerup_done;
	} fptm_demagnetize_request_t;

	typedef struct packed {
		fptm_dm_mode_t mode;
		logic [PWRUP_W-1:0] pwr_cnt;
		logic [HOLD_W-1:0] hold_cnt;
		logic [RUN_W-1:0] run_cnt;
		logic active;
		logic powerup_done;
	} fptm_dm_state_t;

	typedef struct packed {
		logic cmp_s1;
		logic cmp_s2;
		logic cmp_prev;
		logic dmg_s1;
		logic dmg_s2;
		logic gain_s1;
		logic gain_s2;
		logic errp_s1;
		logic errp_s2;
		fptm_ov_mode_t mode;
		logic drive_pol;
		logic drive_inv;
		logic held_pol;
		logic early;
		logic [CNT_W-1:0] half_cnt;
		logic [1:0][CNT_W-1:0] last_half;
		logic [1:0][RUNC_W-1:0] short_run;
		logic [1:0] long_seen;
		logic [CNT_W-1:0] period_cnt;
		logic [RUNC_W-1:0] fast_run;
		logic fast_err;
		logic [CNT_W-1:0] low_cnt;
		logic stuck_err;
		logic err_drive;
		logic gain_sw;
		logic gain_red;
		logic demagnetize_request_sw;
		logic wr_pend;
		logic [ADDR_W-1:0] wr_addr;
		logic [DATA_W-1:0] rdata;
	} fptm_state_t;

	// Saturating increments for the timing counters
	function automatic logic [CNT_W-1:0] cnt_inc(input logic [CNT_W-1:0] v);
		return (v == '1) ? v : v + 1'b1;
	endfunction

	function automatic logic [RUNC_W-1:0] run_inc(input logic [RUNC_W-1:0] v);
		return (v == '1) ? v : v + 1'b1;
	endfunction

endpackage

//--- core/fptm_demagnetize_request_seq.sv
// Demagnetization sequencer with power-up start and request qualification
`timescale 1ns/1ps

module fptm_demagnetize_request_seq #(
	parameter int unsigned RUN_CYC = fptm_pkg::DEMAGNETIZE_REQUEST_RUN_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic req_level,
	input wire logic sw_start,
	output fptm_pkg::fptm_demagnetize_request_t dm_status
);

	fptm_pkg::fptm_dm_state_t st_q;
	fptm_pkg::fptm_dm_state_t st_d;
	logic qualified;

	// Request held long enough: this is its qualifying high cycle
	assign qualified = req_level && (st_q.hold_cnt == fptm_pkg::HOLD_W'(fptm_pkg::DEMAGNETIZE_REQUEST_HOLD_CYC - 1));

	// ********************************
	// Next state
	// ********************************
	always_comb
	begin
		st_d = st_q;
		// Count high cycles of the request, saturating so one pulse starts once
		if (!req_level)
			st_d.hold_cnt = '0;
		else if (st_q.hold_cnt != fptm_pkg::HOLD_W'(fptm_pkg::DEMAGNETIZE_REQUEST_HOLD_CYC))
			st_d.hold_cnt = st_q.hold_cnt + 1'b1;
		unique case (st_q.mode)
			fptm_pkg::DM_POWERUP:
			begin
				// Power-up wait, then start only if the request pin is high
				if (st_q.pwr_cnt == fptm_pkg::PWRUP_W'(fptm_pkg::POWERUP_DELAY_CYC - 1))
				begin
					st_d.powerup_done = 1'b1;
					st_d.run_cnt = '0;
					st_d.active = req_level;
					st_d.mode = req_level ? fptm_pkg::DM_RUN : fptm_pkg::DM_IDLE;
				end
				else
					st_d.pwr_cnt = st_q.pwr_cnt + 1'b1;
			end
			fptm_pkg::DM_IDLE:
			begin
				// Pin request or software request starts a cycle
				if (qualified || sw_start)
				begin
					st_d.mode = fptm_pkg::DM_RUN;
					st_d.run_cnt = '0;
					st_d.active = 1'b1;
				end
			end
			fptm_pkg::DM_RUN:
			begin
				// Requests are ignored while a cycle runs
				if (st_q.run_cnt == fptm_pkg::RUN_W'(RUN_CYC - 1))
				begin
					st_d.mode = fptm_pkg::DM_IDLE;
					st_d.active = 1'b0;
				end
				else
					st_d.run_cnt = st_q.run_cnt + 1'b1;
			end
			default:
				st_d.mode = fptm_pkg::DM_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (reset)
			st_q <= '{mode: fptm_pkg::DM_POWERUP, default: '0};
		else
			st_q <= st_d;
	end

	assign dm_status.active = st_q.active;
	assign dm_status.powerup_done = st_q.powerup_done;

	// ********************************
	// Checks
	// ********************************
	a_dm_start_cause: assert property (@(posedge clk) disable iff (reset)
		$rose(st_q.active) |-> $past(qualified || sw_start || st_q.mode == fptm_pkg::DM_POWERUP))
		else $error("Demagnetization started without a qualified request");
	a_dm_min_run: assert property (@(posedge clk) disable iff (reset)
		$rose(st_q.active) |-> st_q.active [*8])
		else $error("Demagnetization cycle ended too early");
	a_dm_short_ignored: assert property (@(posedge clk) disable iff (reset)
		(st_q.mode == fptm_pkg::DM_IDLE && !qualified && !sw_start) |=> !st_q.active)
		else $error("Unqualified request started demagnetization");

endmodule

//--- core/fptm_demagnetize_request_seq_note.sv
// Spare file of the core folder; it holds no design unit
`timescale 1ns/1ps

//--- testbench/fptm_probe_model.sv
// Behavioural probe coil and saturation comparator facing the monitor
`timescale 1ns/1ps

module fptm_probe_model (
	input wire logic clk,
	input wire logic drive_a,
	input wire logic [1:0] fault,
	input wire logic [7:0] dly_hi,
	input wire logic [7:0] dly_lo,
	output logic cmp
);
	// ********************************
	// Core saturation timing
	// ********************************
	logic last_q = 1'b0;
	logic [7:0] cnt_q = 8'h00;
	logic [7:0] free_q = 8'h00;
	logic drv;

	// Unknown drive before the monitor leaves reset counts as low, so the delay counter never goes unknown
	assign drv = (drive_a === 1'b1);

	// Core leaves saturation on each reversal and saturates again after the delay of that polarity
	// Fault 1 holds the comparator low, fault 2 makes it run free with a period of 8 cycles
	always @(posedge clk)
	begin
		last_q <= drv;
		free_q <= free_q + 8'h01;
		cnt_q <= (drv != last_q) ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hff};
		case (fault)
			2'h1: cmp <= 1'b0;
			2'h2: cmp <= free_q[2];
			default: cmp <= (drv == last_q) && (cnt_q >= (drv ? dly_hi : dly_lo));
		endcase
	end
endmodule

//--- testbench/fluxgate_probe_timing_monitor_bench.sv
// Self-checking bench for the probe timing monitor
`timescale 1ns/1ps

module fluxgate_probe_timing_monitor_bench;
	localparam int RUN = 200;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic dmg = 1'b1;
	logic gain_pin = 1'b0;
	logic [1:0] fault = 2'h0;
	logic [7:0] dly_hi = 8'h14;
	logic [7:0] dly_lo = 8'h14;
	logic hreadyout, hresp, cmp, drv_a, drv_b, pwm_p, pwm_n, gain_red, zero_c, latch, held, dm_act, err_out, err_oe;
	logic last_pwm = 1'b0;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [7:0] d;
	int seed = 38;
	int error_cnt = 0;
	int total_checks = 0;
	int half_len = 0;
	int half_rec [2];
	int lim = 0;
	int tg = 0;
	int t0;

	always #12.5 clk = ~clk;

	fptm_monitor #(.DEMAGNETIZE_REQUEST_RUN_CYC(RUN)) dut_u (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .probe_saturation_comparator(cmp),
		.demagnetize_request(dmg), .gain_select(gain_pin), .error_n_in(err_oe ? err_out : 1'b1),
		.probe_drive_a(drv_a), .probe_drive_b(drv_b), .pwm_p(pwm_p), .pwm_n(pwm_n), .gain_reduce(gain_red),
		.comp_force_zero(zero_c), .overload_latch(latch), .held_polarity(held), .demagnetize_request_active(dm_act),
		.error_n_out(err_out), .error_n_oe(err_oe));

	fptm_probe_model probe_u (.clk(clk), .drive_a(drv_a), .fault(fault), .dly_hi(dly_hi), .dly_lo(dly_lo),
		.cmp(cmp));

	// ********************************
	// Bus, compare and wait tasks
	// ********************************
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_reg({31'h0, got}, {31'h0, exp});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One single word transfer; read data lands in rd
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		@(posedge clk);
		while (hreadyout !== 1'b1)
			@(posedge clk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1)
			@(posedge clk);
		rd = hrdata;
		chk_bit(hresp, fptm_pkg::HRESP_OKAY);
	endtask

	task automatic final_report;
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Each half-period against the minimum and, while set, the expected upper bound
	always @(posedge clk)
	begin
		half_len <= half_len + 1;
		last_pwm <= pwm_p;
		if (!reset && pwm_p !== last_pwm)
		begin
			half_len <= 1;
			tg <= tg + 1;
			half_rec[last_pwm] <= half_len;
			chk_bit(half_len >= fptm_pkg::MIN_HALF_CYC, 1'b1);
			chk_bit(pwm_n, ~pwm_p);
			chk_bit(drv_a, pwm_p);
			if (lim > 0)
				chk_bit(half_len <= lim, 1'b1);
		end
	end

	initial
	begin
		cyc(20000);
		error_cnt++;
		final_report;
	end

	// ********************************
	// Scenarios
	// ********************************
	initial
	begin
		cyc(2);
		reset <= 1'b0;
		cyc(1);
		chk_bit(drv_b, 1'b1);
		chk_bit(err_oe, 1'b0);
		cyc(fptm_pkg::POWERUP_DELAY_CYC - 10);
		chk_bit(dm_act, 1'b0);
		cyc(14);
		chk_bit(dm_act, 1'b1);
		dmg <= 1'b0;
		cyc(RUN / 2);
		chk_bit(err_oe, 1'b1);
		cyc(RUN / 2 + 10);
		chk_bit(dm_act, 1'b0);
		// Software gain bit, gain pin and an unmapped read
		repeat (4)
		begin
			d = 8'($random(seed)) & 8'h02;
			ahb(1'b1, fptm_pkg::REG_CTRL, {24'h0, d});
			ahb(1'b0, fptm_pkg::REG_CTRL, 32'h0);
			chk_reg(rd, {24'h0, d});
			chk_bit(gain_red, d[1]);
		end
		ahb(1'b1, fptm_pkg::REG_CTRL, 32'h0);
		gain_pin <= 1'b1;
		cyc(5);
		chk_bit(gain_red, 1'b1);
		gain_pin <= 1'b0;
		ahb(1'b0, 8'h0c, 32'h0);
		chk_reg(rd, 32'h0);
		// Free oscillation with random delays, equal ones last
		for (int i = 0; i < 3; i++)
		begin
			lim = 0;
			d = 8'(14 + $unsigned($random(seed)) % 16);
			dly_hi <= d;
			dly_lo <= (i == 2) ? d : 8'(14 + $unsigned($random(seed)) % 16);
			cyc(100);
			lim = 38;
			cyc(200);
		end
		lim = 0;
		ahb(1'b0, fptm_pkg::REG_HALF, 32'h0);
		chk_reg({16'h0, rd[31:16]}, {16'h0, rd[15:0]});
		chk_reg(rd, {half_rec[1][15:0], half_rec[0][15:0]});
		chk_bit(latch, 1'b0);
		// One polarity saturating early drives the loop into the latch
		dly_hi <= 8'h02;
		dly_lo <= 8'h28;
		cyc(300);
		chk_bit(latch, 1'b1);
		chk_bit(held, 1'b1);
		t0 = tg;
		cyc(200);
		chk_bit(tg > t0 + 2, 1'b1);
		chk_bit(latch, 1'b1);
		dly_hi <= 8'h14;
		cyc(300);
		chk_bit(latch, 1'b0);
		// Comparator stuck low, started while it is high so the low count begins from zero
		while (cmp !== 1'b1)
			@(posedge clk);
		fault <= 2'h1;
		cyc(fptm_pkg::STUCK_LOW_CYC - 20);
		chk_bit(zero_c, 1'b0);
		cyc(40);
		chk_bit(zero_c, 1'b1);
		chk_bit(err_oe, 1'b1);
		chk_bit(err_out, 1'b0);
		ahb(1'b0, fptm_pkg::REG_STATUS, 32'h0);
		chk_bit(rd[fptm_pkg::ST_ERRPIN_BIT], 1'b0);
		fault <= 2'h0;
		cyc(100);
		chk_bit(zero_c, 1'b0);
		chk_bit(err_oe, 1'b0);
		// Oscillation far too fast
		fault <= 2'h2;
		cyc(80);
		chk_bit(err_oe, 1'b1);
		chk_bit(zero_c, 1'b0);
		fault <= 2'h0;
		cyc(300);
		chk_bit(err_oe, 1'b0);
		// Demagnetize pin: short pulse ignored, long pulse starts a run
		dmg <= 1'b1;
		cyc(fptm_pkg::DEMAGNETIZE_REQUEST_HOLD_CYC - 100);
		dmg <= 1'b0;
		cyc(10);
		chk_bit(dm_act, 1'b0);
		dmg <= 1'b1;
		cyc(fptm_pkg::DEMAGNETIZE_REQUEST_HOLD_CYC + 8);
		chk_bit(dm_act, 1'b1);
		chk_bit(err_oe, 1'b1);
		dmg <= 1'b0;
		cyc(RUN + 10);
		chk_bit(dm_act, 1'b0);
		ahb(1'b1, fptm_pkg::REG_CTRL, 32'h1);
		cyc(3);
		chk_bit(dm_act, 1'b1);
		ahb(1'b0, fptm_pkg::REG_CTRL, 32'h0);
		chk_reg(rd, 32'h0);
		cyc(RUN + 10);
		chk_bit(dm_act, 1'b0);
		final_report;
	end
endmodule
